// file: core/pll_reconfig_pkg.sv
package pll_reconfig_pkg;

  // Scan chain geometry.
  localparam int CHAIN_LEN = 144;
  localparam logic [7:0] CHAIN_MSB = 8'h8f;
  localparam logic [7:0] GRP_BASE = 8'h12;
  localparam logic [7:0] GRP_STRIDE = 8'h12;
  localparam logic [7:0] GRP_HALF = 8'h09;
  localparam logic [7:0] MODE_POS = 8'h08;
  localparam logic [7:0] CP_LSB = 8'h0f;
  localparam logic [7:0] LFR_LSB = 8'h04;
  localparam logic [7:0] LFC_LSB = 8'h02;
  localparam logic [7:0] POST_LSB = 8'h09;
  localparam logic [4:0] CNT_W = 5'h08;
  localparam logic [4:0] MODE_W = 5'h01;
  localparam logic [4:0] NOMINAL_W = 5'h12;
  localparam logic [4:0] CP_W = 5'h03;
  localparam logic [4:0] LFR_W = 5'h05;
  localparam logic [4:0] LFC_W = 5'h02;
  localparam logic [4:0] POST_W = 5'h01;
  localparam logic [4:0] NO_W = 5'h00;
  localparam logic [CHAIN_LEN-1:0] CHAIN_RESET = 144'h0;
  localparam logic [17:0] NOMINAL_BYPASS = 18'h00100;

  // Counter select codes.
  localparam logic [3:0] CNT_C0 = 4'h0;
  localparam logic [3:0] CNT_C4 = 4'h4;
  localparam logic [3:0] CNT_M = 4'h5;
  localparam logic [3:0] CNT_N = 4'h6;
  localparam logic [3:0] CNT_CPLF = 4'h7;
  localparam logic [3:0] CNT_VCO = 4'h8;
  localparam logic [3:0] SLOT_OFS = 4'h2;

  // Parameter select codes.
  localparam logic [2:0] PRM_HIGH = 3'h0;
  localparam logic [2:0] PRM_LOW = 3'h1;
  localparam logic [2:0] PRM_BYPASS = 3'h2;
  localparam logic [2:0] PRM_ODD = 3'h3;
  localparam logic [2:0] PRM_NOMINAL = 3'h4;
  localparam logic [2:0] PRM_CP = 3'h0;
  localparam logic [2:0] PRM_LFR = 3'h1;
  localparam logic [2:0] PRM_LFC = 3'h2;
  localparam logic [2:0] PRM_POST = 3'h0;

  // Register map and fields.
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_PHASE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_READ_DATA = 8'h10;
  localparam logic [31:0] CONTROL_MASK = 32'h0001ff7f;
  localparam logic [31:0] PHASE_MASK = 32'h000000f3;
  localparam int CTL_PRM_LSB = 4;
  localparam int CTL_DATA_LSB = 8;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int CMD_APPLY_BIT = 2;
  localparam int PH_REQ_BIT = 0;
  localparam int PH_DIR_BIT = 1;
  localparam int PH_SEL_LSB = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // Phase step settle time after the step pulse, a least time.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int PHASE_SETTLE_PS = 10000;
  localparam int SETTLE_RAW = (PHASE_SETTLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] PHASE_SETTLE_CYCLES = 4'((SETTLE_RAW < 1) ? 1 : SETTLE_RAW);

  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_SHIFT = 2'b01,
    OP_APPLY = 2'b10
  } op_state_e;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ARM = 2'b01,
    PH_SHIFT = 2'b10
  } phase_state_e;

  typedef struct packed {
    logic [7:0] lo;
    logic [4:0] width;
    logic rev;
  } chain_field_s;

  typedef struct packed {
    logic dir;
    logic [3:0] sel;
  } phase_target_s;

endpackage : pll_reconfig_pkg

// file: core/pll_reconfig_ctrl.sv
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
// Behaviour
// - Write strobe sampled on rising clock; one cycle writes the parameter once.
// - Apply strobe sampled on rising clock; one cycle loads the counters once.
// - Read shifts the selected chain bits out serially, chosen by counter and parameter.
// - Read strobe sampled on rising clock; one cycle reads the parameter once.
// - Reading leaves the stored chain bits unchanged.
// - Busy rises on any operation until done; inputs ignored meanwhile.
// - Applying the configuration never changes the chain.
// - A phase step moves the chosen output by one eighth VCO period.
// - Output clocks keep running during a phase step.
// - Step request latched on falling edge; held at least two cycles.
// - Second rising edge after latch captures direction and target, starts shift.
// - Complete flag falls at that edge and stays low until shift ends.
// - Complete low time may be shorter or longer than one cycle.
// - One shift per request pulse; next only after complete rises again.
// - Chain is 144 bits; bit 143 enters first, bit 0 last.
// - Seven counters hold two 9-bit groups each, bits 143 down to 18.
// - Below counters: pump current, reserved, post divider, resistor, capacitor, reserved.
// - M or N nominal counts derived automatically; one sets bypass.
// - Configuration updated from the chain synchronously when apply takes effect.
// - Counter select 4 bits, parameter select 3 bits, data 9 bits.
module pll_reconfig_ctrl
  import pll_reconfig_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [CHAIN_LEN-1:0] pll_config,
  output logic scan_out_bit,
  output logic scan_out_valid,
  output logic busy,
  output logic phase_shift_pulse,
  output phase_target_s phase_target,
  output logic phase_step_complete
);

  // Maps a counter and parameter selection onto a run of chain bits.
  function automatic chain_field_s decode_field(input logic [3:0] sel, input logic [2:0] prm);
    logic [3:0] slot;
    logic [7:0] grp_hi;
    logic [7:0] grp_lo;
    chain_field_s f;
    slot = (sel == CNT_N) ? 4'h0 : (sel == CNT_M) ? 4'h1 : 4'(sel + SLOT_OFS);
    grp_hi = 8'(GRP_BASE + 8'(GRP_STRIDE * {4'h0, slot}));
    grp_lo = 8'(grp_hi + GRP_HALF);
    f = '{lo: 8'h00, width: NO_W, rev: 1'b0};
    if (sel <= CNT_N) begin
      case (prm)
        PRM_HIGH: f = '{lo: grp_hi, width: CNT_W, rev: 1'b0};
        PRM_LOW: f = '{lo: grp_lo, width: CNT_W, rev: 1'b0};
        PRM_BYPASS: f = '{lo: 8'(grp_hi + MODE_POS), width: MODE_W, rev: 1'b0};
        PRM_ODD: f = '{lo: 8'(grp_lo + MODE_POS), width: MODE_W, rev: 1'b0};
        PRM_NOMINAL: begin
          if (sel == CNT_M || sel == CNT_N) begin
            f = '{lo: grp_hi, width: NOMINAL_W, rev: 1'b0};
          end
        end
        default: f = '{lo: 8'h00, width: NO_W, rev: 1'b0};
      endcase
    end else if (sel == CNT_CPLF) begin
      // Resistor and capacitor fields run lowest-index bit at the top.
      case (prm)
        PRM_CP: f = '{lo: CP_LSB, width: CP_W, rev: 1'b0};
        PRM_LFR: f = '{lo: LFR_LSB, width: LFR_W, rev: 1'b1};
        PRM_LFC: f = '{lo: LFC_LSB, width: LFC_W, rev: 1'b1};
        default: f = '{lo: 8'h00, width: NO_W, rev: 1'b0};
      endcase
    end else if (sel == CNT_VCO && prm == PRM_POST) begin
      f = '{lo: POST_LSB, width: POST_W, rev: 1'b0};
    end
    return f;
  endfunction : decode_field

  // Splits an M or N nominal count into both groups: {odd, low, bypass, high}.
  function automatic logic [17:0] nominal_value(input logic [8:0] n);
    logic [9:0] sum;
    logic [7:0] high;
    logic [8:0] low;
    sum = {1'b0, n} + 10'h001;
    high = sum[8:1];
    low = n - {1'b0, high};
    if (n == 9'h001) begin
      return NOMINAL_BYPASS;
    end
    return {n[0], low[7:0], 1'b0, high};
  endfunction : nominal_value

  // AXI4-Lite slave state.
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [31:0] control_reg, phase_reg;

  // Transfer fires and register selects.
  wire aw_fire = s_axi_awvalid & awready_reg;
  wire w_fire = s_axi_wvalid & wready_reg;
  wire ar_fire = s_axi_arvalid & arready_reg;
  wire wr_commit = aw_have_reg & w_have_reg & ~bvalid_reg;
  wire [7:0] aw_word = {awaddr_reg[7:2], 2'b00};
  wire [7:0] ar_word = {s_axi_araddr[7:2], 2'b00};
  wire sel_ctl = (aw_word == OFS_CONTROL);
  wire sel_cmd = (aw_word == OFS_COMMAND);
  wire sel_ph = (aw_word == OFS_PHASE);
  wire aw_mapped = sel_ctl | sel_cmd | sel_ph | (aw_word == OFS_STATUS) |
                   (aw_word == OFS_READ_DATA);
  wire [31:0] strb_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                           {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire [31:0] control_next = ((control_reg & ~strb_mask) | (wdata_reg & strb_mask)) &
                             CONTROL_MASK;
  wire [31:0] phase_next = ((phase_reg & ~strb_mask) | (wdata_reg & strb_mask)) & PHASE_MASK;

  // Command strobes live one cycle only, so each request acts at most once; one that arrives while busy is dropped.
  wire cmd_go = wr_commit & sel_cmd & wstrb_reg[0];
  wire cmd_write = cmd_go & wdata_reg[CMD_WRITE_BIT];
  wire cmd_read = cmd_go & wdata_reg[CMD_READ_BIT];
  wire cmd_apply = cmd_go & wdata_reg[CMD_APPLY_BIT];
  wire cmd_any = cmd_write | cmd_read | cmd_apply;

  // Handshake next-state terms; address and data may arrive in either order.
  assign aw_have_next = (aw_have_reg | aw_fire) & ~wr_commit;
  assign w_have_next = (w_have_reg | w_fire) & ~wr_commit;
  assign bvalid_next = wr_commit | (bvalid_reg & ~s_axi_bready);
  assign awready_next = ~aw_have_next & ~bvalid_next;
  assign wready_next = ~w_have_next & ~bvalid_next;
  assign rvalid_next = ar_fire | (rvalid_reg & ~s_axi_rready);
  assign arready_next = ~rvalid_next;

  // Scan engine state.
  op_state_e op_state_reg, op_state_next;
  logic [CHAIN_LEN-1:0] chain_reg, chain_snap_reg, pll_config_reg;
  logic [7:0] bit_cnt_reg;
  chain_field_s op_field_reg;
  logic [17:0] op_val_reg;
  logic op_is_write_reg;
  logic busy_reg;
  logic [17:0] read_data_reg;
  logic read_valid_reg;
  logic scan_out_bit_reg, scan_out_valid_reg;

  // Phase step state.
  phase_state_e ph_state_reg;
  logic step_fall_reg, armed_reg;
  logic phase_pulse_reg, phase_complete_reg;
  phase_target_s phase_target_reg;
  logic [3:0] settle_cnt_reg;

  // Status read mux.
  wire [31:0] status_word = {29'h0, read_valid_reg, phase_complete_reg, busy_reg};
  wire [31:0] rd_mux = (ar_word == OFS_CONTROL) ? control_reg :
                       (ar_word == OFS_PHASE) ? phase_reg :
                       (ar_word == OFS_STATUS) ? status_word :
                       (ar_word == OFS_READ_DATA) ? {14'h0, read_data_reg} : 32'h0;
  wire ar_mapped = (ar_word == OFS_CONTROL) | (ar_word == OFS_COMMAND) |
                   (ar_word == OFS_PHASE) | (ar_word == OFS_STATUS) |
                   (ar_word == OFS_READ_DATA);

  // AXI channel registers.
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Payload capture; these need no reset since valid flags guard them.
  always_ff @(posedge clk) begin
    if (aw_fire) awaddr_reg <= s_axi_awaddr;
    if (w_fire) wdata_reg <= s_axi_wdata;
    if (w_fire) wstrb_reg <= s_axi_wstrb;
    if (wr_commit) bresp_reg <= aw_mapped ? RESP_OKAY : RESP_DECERR;
    if (ar_fire) rdata_reg <= rd_mux;
    if (ar_fire) rresp_reg <= ar_mapped ? RESP_OKAY : RESP_DECERR;
  end

  // Software-written control words; the selection is latched again at start.
  always_ff @(posedge clk) begin
    if (srst) begin
      control_reg <= 32'h0;
      phase_reg <= 32'h0;
    end else begin
      if (wr_commit && sel_ctl) control_reg <= control_next;
      if (wr_commit && sel_ph) phase_reg <= phase_next;
    end
  end

  // Operation start; write beats read beats apply, and all wait for idle.
  wire op_idle = (op_state_reg == OP_IDLE);
  wire start_write = cmd_write & op_idle;
  wire start_read = cmd_read & ~cmd_write & op_idle;
  wire start_apply = cmd_apply & ~cmd_write & ~cmd_read & op_idle;
  wire start_shift = start_write | start_read;
  wire [3:0] req_sel = control_reg[3:0];
  wire [2:0] req_prm = control_reg[CTL_PRM_LSB +: 3];
  wire [8:0] req_data = control_reg[CTL_DATA_LSB +: 9];
  wire chain_field_s req_field = decode_field(req_sel, req_prm);
  wire [17:0] req_val = (req_prm == PRM_NOMINAL) ? nominal_value(req_data) : {9'h0, req_data};

  // The chain rotates once round; bit 143 leaves first and returns as bit 0.
  wire [7:0] pos = CHAIN_MSB - bit_cnt_reg;
  wire [7:0] rel = pos - op_field_reg.lo;
  wire in_field = (pos >= op_field_reg.lo) && (rel < {3'h0, op_field_reg.width});
  wire [4:0] vidx = op_field_reg.rev ? 5'(op_field_reg.width - 5'h01 - rel[4:0]) : rel[4:0];
  wire out_bit = chain_reg[CHAIN_LEN-1];
  wire new_bit = (op_is_write_reg && in_field) ? op_val_reg[vidx] : out_bit;
  wire shift_last = (bit_cnt_reg == CHAIN_MSB);

  // Operation state next value.
  always_comb begin
    op_state_next = op_state_reg;
    case (op_state_reg)
      OP_IDLE: begin
        if (start_shift) op_state_next = OP_SHIFT;
        else if (start_apply) op_state_next = OP_APPLY;
      end
      OP_SHIFT: begin
        if (shift_last) op_state_next = OP_IDLE;
      end
      OP_APPLY: op_state_next = OP_IDLE;
      default: op_state_next = OP_IDLE;
    endcase
  end

  // Scan engine control.
  always_ff @(posedge clk) begin
    if (srst) begin
      op_state_reg <= OP_IDLE;
      busy_reg <= 1'b0;
      bit_cnt_reg <= 8'h00;
      op_is_write_reg <= 1'b0;
      op_field_reg <= '{lo: 8'h00, width: NO_W, rev: 1'b0};
      op_val_reg <= 18'h0;
    end else begin
      op_state_reg <= op_state_next;
      busy_reg <= (op_state_next != OP_IDLE);
      if (start_shift) begin
        bit_cnt_reg <= 8'h00;
        op_is_write_reg <= start_write;
        op_field_reg <= req_field;
        op_val_reg <= req_val;
      end else if (op_state_reg == OP_SHIFT) begin
        bit_cnt_reg <= 8'(bit_cnt_reg + 8'h01);
      end
    end
  end

  // Chain, configuration and read-back storage.
  always_ff @(posedge clk) begin
    if (srst) begin
      chain_reg <= CHAIN_RESET;
      chain_snap_reg <= CHAIN_RESET;
      pll_config_reg <= CHAIN_RESET;
    end else begin
      if (start_shift) chain_snap_reg <= chain_reg;
      if (op_state_reg == OP_SHIFT) chain_reg <= {chain_reg[CHAIN_LEN-2:0], new_bit};
      if (op_state_reg == OP_APPLY) pll_config_reg <= chain_reg;
    end
  end

  // Serial output and the collected read word, most significant bit first.
  always_ff @(posedge clk) begin
    if (srst) begin
      scan_out_bit_reg <= 1'b0;
      scan_out_valid_reg <= 1'b0;
      read_data_reg <= 18'h0;
      read_valid_reg <= 1'b0;
    end else begin
      scan_out_valid_reg <= (op_state_reg == OP_SHIFT) & ~op_is_write_reg & in_field;
      scan_out_bit_reg <= out_bit;
      if (start_read) begin
        read_data_reg <= 18'h0;
        read_valid_reg <= 1'b0;
      end else if (op_state_reg == OP_SHIFT && !op_is_write_reg) begin
        if (in_field) read_data_reg <= {read_data_reg[16:0], out_bit};
        if (shift_last) read_valid_reg <= 1'b1;
      end
    end
  end

  // Step request is latched on the falling edge, half a cycle before use.
  always_ff @(negedge clk) begin
    if (srst) begin
      step_fall_reg <= 1'b0;
    end else begin
      step_fall_reg <= phase_reg[PH_REQ_BIT];
    end
  end

  // One step per request: the request must drop before it can arm again.
  wire step_seen = (ph_state_reg == PH_IDLE) & step_fall_reg & armed_reg;

  // Phase step sequencer; the output clocks are never gated by it.
  always_ff @(posedge clk) begin
    if (srst) begin
      ph_state_reg <= PH_IDLE;
      armed_reg <= 1'b0;
      phase_pulse_reg <= 1'b0;
      phase_complete_reg <= 1'b1;
      phase_target_reg <= '{dir: 1'b0, sel: 4'h0};
      settle_cnt_reg <= 4'h0;
    end else begin
      phase_pulse_reg <= 1'b0;
      if (step_seen) armed_reg <= 1'b0;
      else if (!step_fall_reg) armed_reg <= 1'b1;
      case (ph_state_reg)
        PH_IDLE: begin
          if (step_seen) ph_state_reg <= PH_ARM;
        end
        PH_ARM: begin
          phase_target_reg <= '{dir: phase_reg[PH_DIR_BIT], sel: phase_reg[PH_SEL_LSB +: 4]};
          phase_pulse_reg <= 1'b1;
          phase_complete_reg <= 1'b0;
          settle_cnt_reg <= PHASE_SETTLE_CYCLES - 4'h1;
          ph_state_reg <= PH_SHIFT;
        end
        PH_SHIFT: begin
          if (settle_cnt_reg == 4'h0) begin
            phase_complete_reg <= 1'b1;
            ph_state_reg <= PH_IDLE;
          end else begin
            settle_cnt_reg <= settle_cnt_reg - 4'h1;
          end
        end
        default: ph_state_reg <= PH_IDLE;
      endcase
    end
  end

  // Outputs, all straight from flip-flops.
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign pll_config = pll_config_reg;
  assign scan_out_bit = scan_out_bit_reg;
  assign scan_out_valid = scan_out_valid_reg;
  assign busy = busy_reg;
  assign phase_shift_pulse = phase_pulse_reg;
  assign phase_target = phase_target_reg;
  assign phase_step_complete = phase_complete_reg;

  // Checks on the engine and the step sequencer.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_busy_on_start:
    assert property ((start_shift || start_apply) |=> busy_reg)
    else $error("busy did not rise after an accepted operation");

  a_busy_ignores_cmd:
    assert property ((busy_reg && cmd_any) |=> (op_field_reg == $past(op_field_reg)) &&
                     (op_is_write_reg == $past(op_is_write_reg)))
    else $error("command accepted while busy");

  a_shift_length:
    assert property (start_shift |-> ##144 busy_reg ##1 !busy_reg)
    else $error("shift operation did not last 144 cycles");

  a_read_intact:
    assert property ((op_state_reg == OP_SHIFT && shift_last && !op_is_write_reg) |=>
                     (chain_reg == chain_snap_reg))
    else $error("read altered the chain");

  a_apply_keeps_chain:
    assert property ((op_state_reg == OP_APPLY) |=> $stable(chain_reg))
    else $error("apply altered the chain");

  a_apply_updates_config:
    assert property (start_apply |=> ##1 (pll_config_reg == $past(chain_reg)) && !busy_reg)
    else $error("configuration not loaded from the chain");

  a_step_second_edge:
    assert property (step_seen |=> ##1 (phase_pulse_reg && !phase_complete_reg &&
                     phase_target_reg.dir == $past(phase_reg[PH_DIR_BIT])))
    else $error("step not started on the second rising edge");

  a_complete_low_shift:
    assert property ((ph_state_reg == PH_SHIFT) |-> !phase_complete_reg)
    else $error("complete flag high during a shift");

  a_single_step_pulse:
    assert property (phase_pulse_reg |=> !phase_pulse_reg [*2])
    else $error("more than one shift from one request");

  a_rearm_needs_release:
    assert property ((ph_state_reg == PH_IDLE && !armed_reg && step_fall_reg) |=>
                     (ph_state_reg != PH_ARM))
    else $error("step restarted without a released request");

  c_write_done: cover property (op_is_write_reg && shift_last && op_state_reg == OP_SHIFT);
  c_read_done: cover property (!op_is_write_reg && shift_last && in_field);
  c_apply_done: cover property (op_state_reg == OP_APPLY);
  c_step_done: cover property ($rose(phase_complete_reg));

endmodule : pll_reconfig_ctrl

// file: tb/pll_model.sv
`timescale 1ns/100ps
// Stand-in for the PLL: counts phase steps and keeps an output clock alive.
module pll_model
  import pll_reconfig_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic phase_shift_pulse,
  input wire phase_target_s phase_target,
  output logic [7:0] steps,
  output logic [7:0] eighths,
  output logic out_clk
);
  // The output clock free-runs, so a step can never gate it.
  initial out_clk = 1'b0;
  always #1.5 out_clk = ~out_clk;
  // Each pulse moves one eighth of a VCO period, signed by the direction bit.
  always_ff @(posedge clk) begin
    if (srst) begin
      steps <= 8'h00;
      eighths <= 8'h00;
    end else if (phase_shift_pulse) begin
      steps <= steps + 8'h01;
      eighths <= phase_target.dir ? eighths + 8'h01 : eighths - 8'h01;
    end
  end
endmodule : pll_model

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import pll_reconfig_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, scan_out_bit, scan_out_valid, busy, phase_shift_pulse;
  logic phase_step_complete, out_clk;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [CHAIN_LEN-1:0] pll_config;
  logic [7:0] steps, eighths;
  phase_target_s phase_target;
  int err_total = 0, checks = 0;
  logic [31:0] d;
  logic [1:0] r;
  logic [17:0] ser = 18'h0;
  pll_reconfig_ctrl i_dut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pll_config, .scan_out_bit,
    .scan_out_valid, .busy, .phase_shift_pulse, .phase_target, .phase_step_complete);
  pll_model i_pll (.clk, .srst, .phase_shift_pulse, .phase_target, .steps, .eighths,
    .out_clk);
  initial forever #2.5 clk = ~clk;
  // Collect the serial read bits so the serial output is judged as well as the read word.
  always @(posedge clk) begin
    if (scan_out_valid) ser <= {ser[16:0], scan_out_bit};
  end
  // Compare and count; a mismatch is reported at once.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Ready and valid are registered, so the mid-cycle look decides the next edge.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw;
    pa = 1;
    pw = 1;
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (pa || pw) begin
      @(negedge clk);
      if (s_axi_awready) pa = 0;
      if (s_axi_wready) pw = 0;
      @(posedge clk);
      if (!pa) s_axi_awvalid <= 1'b0;
      if (!pw) s_axi_wvalid <= 1'b0;
    end
    do @(negedge clk); while (!s_axi_bvalid);
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(negedge clk); while (!s_axi_arready);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // Issue a scan command, see busy unless it is an apply, then poll until it clears.
  task automatic cmd(input logic [31:0] c);
    axi_wr(OFS_COMMAND, c);
    axi_rd(OFS_STATUS);
    if (c != 32'h4) chk(d[0], 1'b1);
    do axi_rd(OFS_STATUS); while (d[0]);
  endtask : cmd
  function automatic logic [31:0] ctl(logic [3:0] s, logic [2:0] p, logic [8:0] v);
    return (32'(v) << CTL_DATA_LSB) | (32'(p) << CTL_PRM_LSB) | 32'(s);
  endfunction : ctl
  // Write C0 high, read it back once before an apply and twice after; an apply while busy is lost.
  task automatic t_scan;
    axi_wr(OFS_CONTROL, ctl(CNT_C0, PRM_HIGH, 9'h005));
    axi_wr(OFS_COMMAND, 32'h1);
    axi_wr(OFS_COMMAND, 32'h4);
    do axi_rd(OFS_STATUS); while (d[0]);
    chk(32'(pll_config[61:54]), 32'h0);
    cmd(32'h2);
    axi_rd(OFS_READ_DATA);
    chk(d, 32'h5);
    chk(32'(ser[7:0]), 32'h5);
    cmd(32'h4);
    chk(32'(pll_config[62:54]), 32'h005);
    cmd(32'h2);
    cmd(32'h2);
    axi_rd(OFS_READ_DATA);
    chk(d, 32'h5);
    $display("test scan done");
  endtask : t_scan
  // C1 set by hand for an odd count of five; nominal seven on M splits automatically.
  task automatic t_nominal;
    axi_wr(OFS_CONTROL, ctl(4'(CNT_C0 + 4'h1), PRM_HIGH, 9'h003));
    cmd(32'h1);
    axi_wr(OFS_CONTROL, ctl(4'(CNT_C0 + 4'h1), PRM_LOW, 9'h002));
    cmd(32'h1);
    axi_wr(OFS_CONTROL, ctl(4'(CNT_C0 + 4'h1), PRM_ODD, 9'h001));
    cmd(32'h1);
    axi_wr(OFS_CONTROL, ctl(CNT_M, PRM_NOMINAL, 9'h007));
    cmd(32'h1);
    cmd(32'h4);
    chk(32'(pll_config[53:36]), {14'h0, 18'h20604});
    chk(32'(pll_config[89:72]), 32'h20403);
    $display("test nominal done");
  endtask : t_nominal
  // One step up on counter five; the request drops only after complete falls.
  task automatic t_phase;
    axi_wr(OFS_PHASE, 32'h53);
    do @(negedge clk); while (phase_step_complete);
    chk(32'(phase_target), 32'h15);
    axi_wr(OFS_PHASE, 32'h52);
    do @(negedge clk); while (!phase_step_complete);
    repeat (4) @(negedge clk);
    chk({steps, eighths}, 16'h0101);
    axi_rd(8'h40);
    chk(r, RESP_DECERR);
    $display("test phase done");
  endtask : t_phase
  task automatic print_verdict;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // A scan operation takes under 200 cycles, so this span is generous.
  initial begin
    #200000;
    err_total++;
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_scan;
    t_nominal;
    t_phase;
    print_verdict;
  end
endmodule : tb_top
